// file: logic/sps_regs.svh
// constants of the synchronous shift serial port: counts, encodings
// assumes a 200 MHz system clock standing in for the oscillator
// Functional notes
// - buffer write loads transmit register; buffer read returns separate receive buffer
// - asynchronous operation transmits and receives at the same time
// - mode 0 moves data both ways on data pin, clock on clock pin
// - mode 0 clock always made by the device, so link is half duplex
// - mode 0 frame is eight bits, least significant bit first
// - mode 0 bit rate is clock/12 when speed select 0, clock/4 when 1
// - mode 0 buffer write starts clock and shifts out all eight bits
// - fast: data one clock before clock falls, clock low two clocks
// - slow: data three clocks before clock falls, clock low six clocks
// - two mode select bits choose mode; zero means synchronous shift
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

`define SPS_MODE_SYNC 2'b00
`define SPS_FRAME_BITS 4'd8
`define SPS_FAST_LEAD 4'd1
`define SPS_FAST_LOW 4'd2
`define SPS_FAST_PER 4'd4
`define SPS_SLOW_LEAD 4'd3
`define SPS_SLOW_LOW 4'd6
`define SPS_SLOW_PER 4'd12
`define SPS_CLK_HZ 200000000
`define SPS_ASYNC_BAUD 115200
`define SPS_ASYNC_BIT_CYC (`SPS_CLK_HZ / `SPS_ASYNC_BAUD)
`define SPS_ASYNC_FRAME 4'd10

`endif

// file: logic/sps_pkg.sv
// types of the synchronous shift serial port
// assumes sps_regs.svh for the numeric constants
package sps_pkg;

    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_M0TX = 2'b01,
        SPS_M0RX = 2'b10,
        SPS_ATX = 2'b11
    } sps_tx_state_t;

    typedef enum logic [1:0] {
        SPS_RWAIT = 2'b00,
        SPS_RSTART = 2'b01,
        SPS_RDATA = 2'b10,
        SPS_RSTOP = 2'b11
    } sps_rx_state_t;

    typedef struct packed {
        sps_tx_state_t txState;
        sps_rx_state_t rxState;
        logic fast;
        logic [3:0] phase;
        logic [3:0] bitCnt;
        logic [11:0] baudCnt;
        logic [7:0] txShift;
        logic [7:0] rxShift;
        logic [11:0] arxCnt;
        logic [3:0] arxBits;
        logic [7:0] arxShift;
        logic [7:0] rxBuf;
        logic txDone;
        logic rxDone;
        logic txdPin;
        logic rxdOut;
        logic rxdOe;
    } sps_state_t;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic out;
    } sps_sync_t;

endpackage

// file: logic/sps_sync3.sv
// three-flop input synchroniser with agreement filter
// assumes din is asynchronous to clock
`timescale 1ns/1ps
module sps_sync3 (
    input wire logic clock,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    import sps_pkg::*;

    sps_sync_t st_r;
    sps_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ff1 = din;
        st_nxt.ff2 = st_r.ff1;
        st_nxt.ff3 = st_r.ff2;
        if (st_r.ff2 == st_r.ff3) begin
            st_nxt.out = st_r.ff3;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, out: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.out;
endmodule

// file: logic/sps_serial_port.sv
// serial port: synchronous shift mode 0 and a plain 8-bit async mode
// assumes a pin wrapper resolves the data pin from rxdOut and rxdOe
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_serial_port (
    input wire logic clock,
    input wire logic srst,
    input wire logic modeSelectLow,
    input wire logic modeSelectHigh,
    input wire logic shiftSpeedSelect,
    input wire logic receiveEnable,
    input wire logic bufWrite,
    input wire logic [7:0] bufWdata,
    input wire logic txFlagClear,
    input wire logic rxFlagClear,
    input wire logic rxdIn,
    output logic rxdOut,
    output logic rxdOe,
    output logic txdPin,
    output logic [7:0] bufRdata,
    output logic txDone,
    output logic rxDone,
    output logic txBusy
);
    import sps_pkg::*;

    sps_state_t st_r;
    sps_state_t st_nxt;
    sps_pkg::sps_tx_state_t txState;
    logic rxdSync;
    logic syncMode;
    logic [3:0] leadC;
    logic [3:0] lowC;
    logic [3:0] perC;
    logic [11:0] bitCyc;
    logic [11:0] halfCyc;
    logic busy_r;

    // --------------------------------------------------------------
    // data pin synchroniser
    // --------------------------------------------------------------
    sps_sync3 u_rxdSync (
        .clock(clock),
        .srst(srst),
        .din(rxdIn),
        .dout(rxdSync)
    );

    assign syncMode = ({modeSelectHigh, modeSelectLow} == `SPS_MODE_SYNC);
    assign leadC = st_r.fast ? `SPS_FAST_LEAD : `SPS_SLOW_LEAD;
    assign lowC = st_r.fast ? `SPS_FAST_LOW : `SPS_SLOW_LOW;
    assign perC = st_r.fast ? `SPS_FAST_PER : `SPS_SLOW_PER;
    assign bitCyc = 12'(`SPS_ASYNC_BIT_CYC);
    assign halfCyc = 12'(`SPS_ASYNC_BIT_CYC / 2);
    assign txState = st_r.txState;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // clears first so a same-cycle set wins
        if (txFlagClear) begin
            st_nxt.txDone = 1'b0;
        end
        if (rxFlagClear) begin
            st_nxt.rxDone = 1'b0;
        end
        case (st_r.txState)
            SPS_IDLE: begin
                st_nxt.txdPin = 1'b1;
                st_nxt.rxdOe = 1'b0;
                st_nxt.phase = 4'h0;
                st_nxt.bitCnt = 4'h0;
                st_nxt.baudCnt = 12'h000;
                st_nxt.fast = shiftSpeedSelect;
                if (bufWrite) begin
                    st_nxt.txShift = bufWdata;
                    if (syncMode) begin
                        // write starts mode 0 shift out
                        st_nxt.txState = SPS_M0TX;
                        st_nxt.rxdOe = 1'b1;
                        st_nxt.rxdOut = bufWdata[0];
                    end else begin
                        st_nxt.txState = SPS_ATX;
                        st_nxt.txdPin = 1'b0;
                    end
                end else if (syncMode && receiveEnable && !st_r.rxDone) begin
                    st_nxt.txState = SPS_M0RX;
                    st_nxt.rxShift = 8'h00;
                end
            end
            SPS_M0TX, SPS_M0RX: begin
                // clock on clock pin, data on data pin
                st_nxt.phase = st_r.phase + 4'h1;
                if (st_r.phase == leadC - 4'h1) begin
                    st_nxt.txdPin = 1'b0;
                end
                if (st_r.phase == leadC + lowC - 4'h1) begin
                    st_nxt.txdPin = 1'b1;
                    // sample where the far end shifts on the rise
                    st_nxt.rxShift = {rxdSync, st_r.rxShift[7:1]};
                end
                if (st_r.phase == perC - 4'h1) begin
                    st_nxt.phase = 4'h0;
                    st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                    st_nxt.txShift = {1'b0, st_r.txShift[7:1]};
                    st_nxt.rxdOut = st_r.txShift[1];
                    if (st_r.bitCnt == `SPS_FRAME_BITS - 4'h1) begin
                        st_nxt.txState = SPS_IDLE;
                        st_nxt.rxdOe = 1'b0;
                        st_nxt.txdPin = 1'b1;
                        if (st_r.txState == SPS_M0TX) begin
                            st_nxt.txDone = 1'b1;
                        end else begin
                            st_nxt.rxBuf = st_nxt.rxShift;
                            st_nxt.rxDone = 1'b1;
                        end
                    end
                end
            end
            SPS_ATX: begin
                st_nxt.baudCnt = st_r.baudCnt + 12'h001;
                if (st_r.baudCnt == bitCyc - 12'h001) begin
                    st_nxt.baudCnt = 12'h000;
                    st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                    if (st_r.bitCnt == `SPS_ASYNC_FRAME - 4'h1) begin
                        st_nxt.txState = SPS_IDLE;
                        st_nxt.txDone = 1'b1;
                    end else if (st_r.bitCnt == `SPS_FRAME_BITS) begin
                        st_nxt.txdPin = 1'b1;
                    end else begin
                        st_nxt.txdPin = st_r.txShift[0];
                        st_nxt.txShift = {1'b0, st_r.txShift[7:1]};
                    end
                end
            end
            default: begin
                st_nxt.txState = SPS_IDLE;
            end
        endcase
        // async receiver runs beside the transmitter
        if (syncMode || !receiveEnable) begin
            st_nxt.rxState = SPS_RWAIT;
            st_nxt.arxCnt = 12'h000;
        end else begin
            st_nxt.arxCnt = st_r.arxCnt + 12'h001;
            case (st_r.rxState)
                SPS_RWAIT: begin
                    st_nxt.arxCnt = 12'h000;
                    if (!rxdSync) begin
                        st_nxt.rxState = SPS_RSTART;
                    end
                end
                SPS_RSTART: begin
                    if (st_r.arxCnt == halfCyc - 12'h001) begin
                        st_nxt.arxCnt = 12'h000;
                        st_nxt.arxBits = 4'h0;
                        st_nxt.rxState = rxdSync ? SPS_RWAIT : SPS_RDATA;
                    end
                end
                SPS_RDATA: begin
                    if (st_r.arxCnt == bitCyc - 12'h001) begin
                        st_nxt.arxCnt = 12'h000;
                        st_nxt.arxShift = {rxdSync, st_r.arxShift[7:1]};
                        st_nxt.arxBits = st_r.arxBits + 4'h1;
                        if (st_r.arxBits == `SPS_FRAME_BITS - 4'h1) begin
                            st_nxt.rxState = SPS_RSTOP;
                        end
                    end
                end
                SPS_RSTOP: begin
                    if (st_r.arxCnt == bitCyc - 12'h001) begin
                        st_nxt.rxState = SPS_RWAIT;
                        if (rxdSync) begin
                            st_nxt.rxBuf = st_r.arxShift;
                            st_nxt.rxDone = 1'b1;
                        end
                    end
                end
                default: begin
                    st_nxt.rxState = SPS_RWAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
            st_r.txdPin <= 1'b1;
            st_r.rxdOut <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            busy_r <= (st_nxt.txState != SPS_IDLE);
        end
    end

    assign rxdOut = st_r.rxdOut;
    assign rxdOe = st_r.rxdOe;
    assign txdPin = st_r.txdPin;
    assign bufRdata = st_r.rxBuf;
    assign txDone = st_r.txDone;
    assign rxDone = st_r.rxDone;
    assign txBusy = busy_r;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    logic [3:0] fallCnt_r;
    always_ff @(posedge clock) begin
        if (srst || st_r.txState == SPS_IDLE) begin
            fallCnt_r <= 4'h0;
        end else if (st_r.txdPin && !st_nxt.txdPin) begin
            fallCnt_r <= fallCnt_r + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_write_starts: assert property (
        (txState == SPS_IDLE && bufWrite && syncMode) |=> (txState == SPS_M0TX && rxdOe))
        else $error("mode 0 write did not start shifting");
    a_fast_lead: assert property (
        (txState == SPS_M0TX && st_r.fast && st_r.phase == 4'h0) |-> ##1 $fell(txdPin))
        else $error("fast data lead not one clock");
    a_slow_lead: assert property (
        (txState == SPS_M0TX && !st_r.fast && st_r.phase == 4'h0)
        |-> txdPin ##1 txdPin ##1 txdPin ##1 $fell(txdPin))
        else $error("slow data lead not three clocks");
    a_fast_low: assert property (
        ($fell(txdPin) && syncMode && st_r.fast) |-> !txdPin ##1 !txdPin ##1 txdPin)
        else $error("fast clock low not two clocks");
    a_slow_low: assert property (
        ($fell(txdPin) && syncMode && !st_r.fast) |-> !txdPin[*6] ##1 txdPin)
        else $error("slow clock low not six clocks");
    a_eight_falls: assert property (
        (txState == SPS_M0TX && st_nxt.txState == SPS_IDLE) |-> fallCnt_r == 4'd8)
        else $error("mode 0 frame not eight clocks");
    a_lsb_first: assert property (
        (txState == SPS_IDLE && bufWrite && syncMode) |=> rxdOut == $past(bufWdata[0]))
        else $error("first bit not lsb");
    a_done_wins: assert property (
        (txState == SPS_M0TX && st_nxt.txState == SPS_IDLE) |=> (txDone && txdPin && !rxdOe))
        else $error("frame end flag or idle clock wrong");
    a_rx_no_drive: assert property (
        (txState == SPS_M0RX) |-> !rxdOe)
        else $error("data pin driven while receiving");
endmodule

// file: test/sps_shift_partner.sv
// far-end shift register for mode 0 of the serial port
// assumes shiftClk is the port's shift clock and idles high
`timescale 1ns/1ps
module sps_shift_partner (
    input wire logic shiftClk,
    input wire logic dataOut,
    input wire logic dataOe,
    input wire logic loadReq,
    input wire logic [7:0] loadData,
    output logic dataLine,
    output logic [7:0] capByte,
    output int capCount
);
    logic [7:0] sendReg;
    int sendLeft;
    initial begin
        dataLine = 1'b0;
        capByte = 8'h00;
        capCount = 0;
        sendLeft = 0;
    end
    always @(posedge loadReq) begin
        sendReg = loadData;
        sendLeft = 8;
        dataLine = loadData[0];
    end
    // capture on rising edge, shift own data out after it
    always @(posedge shiftClk) begin
        if (dataOe === 1'b1) begin
            capByte = {dataOut, capByte[7:1]};
            capCount++;
        end else if (sendLeft > 0) begin
            #1;
            sendReg = {1'b0, sendReg[7:1]};
            sendLeft--;
            // released line shows the inverse of the last bit
            dataLine = (sendLeft > 0) ? sendReg[0] : ~dataLine;
        end
    end
endmodule

// file: test/sps_serial_port_tb_top.sv
// self-checking bench of the serial port: mode 0 both ways, async duplex
// assumes sps_shift_partner as far end of the shift link
`timescale 1ns/1ps
module sps_serial_port_tb_top;
    logic clock, srst, modeSelectLow, modeSelectHigh, shiftSpeedSelect;
    logic receiveEnable, bufWrite, txFlagClear, rxFlagClear, rxdIn, rxdOut, rxdOe;
    logic txdPin, txDone, rxDone, txBusy, farLine, benchLine, benchDrive, farLoad;
    logic prevShift, oeSeen;
    logic [7:0] bufWdata, bufRdata, farByte, farData;
    int failures, tests_run, seed, lowCnt, fallCnt, farCount, cyc, fallAt;
    byte unsigned expQ[$];

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    assign rxdIn = rxdOe ? rxdOut : (benchDrive ? benchLine : farLine);

    sps_serial_port i_sps_serial_port (.clock(clock), .srst(srst),
        .modeSelectLow(modeSelectLow), .modeSelectHigh(modeSelectHigh),
        .shiftSpeedSelect(shiftSpeedSelect), .receiveEnable(receiveEnable),
        .bufWrite(bufWrite), .bufWdata(bufWdata), .txFlagClear(txFlagClear),
        .rxFlagClear(rxFlagClear), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
        .txdPin(txdPin), .bufRdata(bufRdata), .txDone(txDone), .rxDone(rxDone),
        .txBusy(txBusy));
    sps_shift_partner i_sps_shift_partner (.shiftClk(txdPin), .dataOut(rxdOut),
        .dataOe(rxdOe), .loadReq(farLoad), .loadData(farData), .dataLine(farLine),
        .capByte(farByte), .capCount(farCount));

    // ------------------------------
    // shift clock watcher
    // ------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (txdPin === 1'b0) lowCnt <= lowCnt + 1;
        if (prevShift === 1'b1 && txdPin === 1'b0) begin
            fallCnt <= fallCnt + 1;
            if (fallCnt == 0) fallAt <= cyc;
        end
        if (rxdOe === 1'b1) oeSeen <= 1'b1;
        prevShift <= txdPin;
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_flag(input logic rx, input int limit, output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (((rx ? rxDone : txDone) !== 1'b1) && n < limit);
        if (n >= limit) begin
            failures++;
            end_of_test();
        end
        @(negedge clock);
    endtask

    task automatic pulse_clear();
        txFlagClear = 1'b1;
        rxFlagClear = 1'b1;
        @(negedge clock);
        txFlagClear = 1'b0;
        rxFlagClear = 1'b0;
        @(negedge clock);
    endtask

    task automatic m0_send(input logic fast, input logic [7:0] d);
        int n, k;
        shiftSpeedSelect = fast;
        bufWdata = d;
        bufWrite = 1'b1;
        lowCnt = 0;
        fallCnt = 0;
        k = cyc;
        expQ.push_back(d);
        @(negedge clock);
        bufWrite = 1'b0;
        @(negedge clock);
        // write and speed change in mid-frame must be ignored
        bufWrite = 1'b1;
        bufWdata = ~d;
        shiftSpeedSelect = ~fast;
        @(negedge clock);
        bufWrite = 1'b0;
        shiftSpeedSelect = fast;
        wait_flag(1'b0, 200, n);
        // eight periods of 4 or 12 clocks, counted from the write edge
        check("frame length", fast ? 32 : 96, n + 2);
        // lead of 1 or 3 clocks, plus the watcher's one-cycle view delay
        check("data lead", fast ? 2 : 4, fallAt - k);
        check("low cycles", fast ? 16 : 48, lowCnt);
        check("falls", 8, fallCnt);
        check("far byte", expQ.pop_front(), farByte);
        check("idle after", 3'b100, {txdPin, rxdOe, txBusy});
        pulse_clear();
        check("flag cleared", 0, txDone);
    endtask

    task automatic m0_recv(input logic [7:0] d);
        int n;
        shiftSpeedSelect = 1'b0;
        farData = d;
        farLoad = 1'b1;
        @(negedge clock);
        farLoad = 1'b0;
        receiveEnable = 1'b1;
        oeSeen = 1'b0;
        fallCnt = 0;
        wait_flag(1'b1, 300, n);
        receiveEnable = 1'b0;
        check("rx data", d, bufRdata);
        check("rx no drive", 0, oeSeen);
        check("rx clocks", 8, fallCnt);
        pulse_clear();
    endtask

    task automatic async_duplex(input logic [1:0] mode, input logic [7:0] dt,
        input logic [7:0] dr);
        logic [9:0] got;
        int n;
        {modeSelectHigh, modeSelectLow} = mode;
        benchDrive = 1'b1;
        // let the idle line settle through the synchroniser first
        repeat (4) @(negedge clock);
        bufWdata = dt;
        bufWrite = 1'b1;
        receiveEnable = 1'b1;
        @(negedge clock);
        bufWrite = 1'b0;
        fork
            for (int i = 0; i < 10; i++) begin
                benchLine = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : dr[i - 1];
                #8680;
            end
            begin
                repeat (868) @(negedge clock);
                for (int i = 0; i < 10; i++) begin
                    got[i] = txdPin;
                    repeat (1736) @(negedge clock);
                end
            end
        join
        wait_flag(1'b1, 2000, n);
        wait_flag(1'b0, 2000, n);
        check("async tx frame", {1'b1, dt, 1'b0}, got);
        check("async rx data", dr, bufRdata);
        {modeSelectHigh, modeSelectLow} = 2'b00;
        receiveEnable = 1'b0;
        benchDrive = 1'b0;
        pulse_clear();
    endtask

    initial begin
        seed = 5518;
        failures = 0;
        tests_run = 0;
        cyc = 0;
        {srst, modeSelectLow, modeSelectHigh, shiftSpeedSelect, receiveEnable} = 5'h10;
        {bufWrite, txFlagClear, rxFlagClear, benchDrive, farLoad} = 5'h00;
        benchLine = 1'b1;
        bufWdata = 8'h00;
        farData = 8'h00;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        check("reset pins", 3'b100, {txdPin, rxdOe, txBusy});
        check("reset rdata", 0, bufRdata);
        for (int k = 0; k < 4; k++) m0_send(k[0], 8'($random(seed)));
        m0_send(1'b1, 8'h80);
        m0_send(1'b0, 8'h01);
        m0_recv(8'($random(seed)));
        m0_recv(8'h5a);
        m0_send(1'b1, 8'hc3);
        check("rx kept", 8'h5a, bufRdata);
        async_duplex(2'b01, 8'($random(seed)), 8'($random(seed)));
        async_duplex(2'b10, 8'($random(seed)), 8'($random(seed)));
        async_duplex(2'b11, 8'($random(seed)), 8'($random(seed)));
        end_of_test();
    end
endmodule
